//--- rtl/rtot_defines.svh
// register offsets, field positions, reset values and timing counts of the totalizer
`ifndef RTOT_DEFINES_SVH
`define RTOT_DEFINES_SVH
`define RTOT_OFS_CTRL 8'h00
`define RTOT_OFS_INPUT 8'h04
`define RTOT_OFS_THRESH 8'h08
`define RTOT_OFS_TOTAL 8'h0c
`define RTOT_OFS_STATUS 8'h10
`define RTOT_OFS_INT_STAT 8'h14
`define RTOT_OFS_INT_MASK 8'h18
`define RTOT_OFS_SCALE 8'h1c
`define RTOT_CTRL_RUN 0
`define RTOT_CTRL_FREEZE 1
`define RTOT_CTRL_CLEAR 2
`define RTOT_CTRL_BAD 3
`define RTOT_CTRL_DP_LO 4
`define RTOT_CTRL_DP_HI 6
`define RTOT_DP_MAX 3'h4
`define RTOT_CTRL_RESET 32'h0000_0000
`define RTOT_SCALE_RESET 32'h3f80_0000
`define RTOT_FP_MAX_POS 32'h7f7f_ffff
`define RTOT_FP_MAX_NEG 32'hff7f_ffff
`define RTOT_FP_ZERO 32'h0000_0000
`define RTOT_TICK_NS 100000
`define RTOT_CLK_NS 100
`define RTOT_TICK_CYCLES (`RTOT_TICK_NS / `RTOT_CLK_NS)
`define RTOT_INT_ALARM 0
`define RTOT_INT_SAT 1
`define RTOT_INT_BAD 2
`endif

//--- rtl/rtot_pkg.sv
// types shared by the totalizer modules
package rtot_pkg;
    typedef enum logic [1:0] {
        RTOT_IDLE = 2'b00,
        RTOT_MUL = 2'b01,
        RTOT_ADD = 2'b10,
        RTOT_DONE = 2'b11
    } rtot_step_e;
    typedef logic [31:0] rtot_word_t;
endpackage : rtot_pkg

//--- rtl/rtot_fp_if.sv
// interface carrying one float operation between the totalizer and its arithmetic unit
`timescale 1ns/10ps
interface rtot_fp_if;
    logic [31:0] a;
    logic [31:0] b;
    logic mul;
    logic [31:0] res;
    logic ovf;
    modport user (output a, output b, output mul, input res, input ovf);
    modport unit (input a, input b, input mul, output res, output ovf);
endinterface : rtot_fp_if

//--- rtl/rtot_fp_unit.sv
// combinational single-precision add or multiply with saturation and flush of tiny results
`timescale 1ns/10ps
`include "rtot_defines.svh"
module rtot_fp_unit
    import rtot_pkg::*;
(
    // operation
    rtot_fp_if.unit fp
);
    logic sa;
    logic sb;
    logic [7:0] ea;
    logic [7:0] eb;
    logic [23:0] ma;
    logic [23:0] mb;
    logic [47:0] prod;
    logic [9:0] ex;
    logic [25:0] sum;
    logic [23:0] sub_m;
    logic [7:0] d;
    logic s;
    logic [9:0] e;
    logic [47:0] m;
    logic ovf;
    logic [31:0] r;
    integer i;
    integer lz;
    always_comb
    begin
        sa = fp.a[31];
        sb = fp.b[31];
        ea = fp.a[30:23];
        eb = fp.b[30:23];
        ma = (ea == 8'h00) ? 24'h0 : {1'b1, fp.a[22:0]};
        mb = (eb == 8'h00) ? 24'h0 : {1'b1, fp.b[22:0]};
        prod = 48'h0;
        sum = 26'h0;
        sub_m = 24'h0;
        d = 8'h0;
        ex = 10'h0;
        s = 1'b0;
        e = 10'h0;
        m = 48'h0;
        ovf = 1'b0;
        r = 32'h0;
        lz = 0;
        if (fp.mul)
        begin
            prod = ma * mb;
            s = sa ^ sb;
            ex = {2'b00, ea} + {2'b00, eb} - 10'd127;
            if (prod[47])
            begin
                m = prod;
                e = ex + 10'd1;
            end
            else
            begin
                m = {prod[46:0], 1'b0};
                e = ex;
            end
            if (ma == 24'h0 || mb == 24'h0)
                m = 48'h0;
        end
        else
        begin
            if ({ea, ma} >= {eb, mb})
            begin
                d = ea - eb;
                sub_m = (d > 8'd25) ? 24'h0 : (mb >> d);
                sum = (sa == sb) ? {2'b00, ma} + {2'b00, sub_m} : {2'b00, ma} - {2'b00, sub_m};
                s = sa;
                e = {2'b00, ea};
            end
            else
            begin
                d = eb - ea;
                sub_m = (d > 8'd25) ? 24'h0 : (ma >> d);
                sum = (sa == sb) ? {2'b00, mb} + {2'b00, sub_m} : {2'b00, mb} - {2'b00, sub_m};
                s = sb;
                e = {2'b00, eb};
            end
            if (sum[24])
            begin
                m = {sum[24:0], 23'h0};
                e = e + 10'd1;
            end
            else
            begin
                lz = 0;
                for (i = 23; i >= 0; i = i - 1)
                    if (sum[i] && lz == 0)
                        lz = 24 - i;
                m = (lz == 0) ? 48'h0 : ({sum[23:0], 24'h0} << (lz - 1));
                e = e - 10'(lz - 1);
            end
        end
        if (m[47] == 1'b0 || e[9] || e == 10'h0)
            r = 32'h0;
        else if (e >= 10'd255)
        begin
            ovf = 1'b1;
            r = s ? `RTOT_FP_MAX_NEG : `RTOT_FP_MAX_POS;
        end
        else
            r = {s, e[7:0], m[46:24]};
    end
    assign fp.res = r;
    assign fp.ovf = ovf;
endmodule : rtot_fp_unit

//--- rtl/rtot_alarm_cmp.sv
// signed float compare of total against threshold
`timescale 1ns/10ps
module rtot_alarm_cmp
    import rtot_pkg::*;
(
    // operands
    input wire logic [31:0] total,
    input wire logic [31:0] thresh,
    // result
    output logic hit
);
    logic tz;
    logic tneg;
    logic gt;
    logic lt;
    always_comb
    begin
        tz = thresh[30:0] == 31'h0;
        tneg = thresh[31];
        // signed value ordering of ieee floats via sign-adjusted keys
        gt = ({~total[31], total[31] ? ~total[30:0] : total[30:0]}
            > {~thresh[31], thresh[31] ? ~thresh[30:0] : thresh[30:0]});
        lt = ({~total[31], total[31] ? ~total[30:0] : total[30:0]}
            < {~thresh[31], thresh[31] ? ~thresh[30:0] : thresh[30:0]});
        if (tz)
            hit = 1'b0;
        else if (tneg)
            hit = lt;
        else
            hit = gt;
    end
endmodule : rtot_alarm_cmp

//--- rtl/rtot_totalizer.sv
// rate totalizer with alarm, wishbone slave and interrupt
// Notes on behaviour
// - while running the total gains the integrated input each update and the alarm is checked.
// - while frozen the total stays but the alarm is still checked against it.
// - clear sets the total to zero and drops the alarm.
// - a positive threshold sets the alarm once the total is strictly above it.
// - a negative threshold sets the alarm once the total is strictly below it.
// - a zero threshold keeps the alarm off.
// - the alarm drops on clear, on loss of run, or on a threshold write.
// - the total saturates at the largest float magnitudes.
// - accumulation is float addition so tiny increments are absorbed.
// - a bad input quality stops accumulation.
// - decimal places setting 0 to 4, default 0.
// - alarm and total are read only, alarm 1 for on.
// - run, freeze and clear are one bit, 1 asserted.
// - integration only with run on and freeze off.
//
// Design decisions made here: register access over Wishbone and the register addresses.
`timescale 1ns/10ps
`include "rtot_defines.svh"
module rtot_totalizer
    import rtot_pkg::*;
#(
    parameter int TICK_CYCLES = `RTOT_TICK_CYCLES
)
(
    // clock and reset
    input wire logic clock,
    input wire logic resetn,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic wb_err_o,
    // results
    output logic [31:0] total,
    output logic alarm_flag,
    output logic irq
);
    typedef struct packed {
        logic run;
        logic freeze_control;
        logic clear;
        logic bad;
        logic [2:0] total_decimal_places;
        logic [31:0] in_value;
        logic [31:0] alarm_threshold;
        logic [31:0] scale;
        logic [31:0] total;
        logic [31:0] incr;
        logic alarm_flag;
        logic [2:0] int_stat;
        logic [2:0] int_mask;
        logic [31:0] tick_cnt;
        rtot_step_e step;
        logic ack;
        logic err;
        logic [31:0] rdata;
    } rtot_state_s;

    // state after reset
    localparam rtot_state_s ST_RESET = '{
        run: 1'b0,
        freeze_control: 1'b0,
        clear: 1'b0,
        bad: 1'b0,
        total_decimal_places: 3'h0,
        in_value: 32'h0,
        alarm_threshold: 32'h0,
        scale: `RTOT_SCALE_RESET,
        total: `RTOT_FP_ZERO,
        incr: 32'h0,
        alarm_flag: 1'b0,
        int_stat: 3'h0,
        int_mask: 3'h0,
        tick_cnt: 32'h0,
        step: RTOT_IDLE,
        ack: 1'b0,
        err: 1'b0,
        rdata: 32'h0
    };

    rtot_state_s st_reg;
    rtot_state_s st_next;
    rtot_fp_if fp ();
    logic hit;
    logic [31:0] wmask;
    logic req;
    logic wr;
    logic [2:0] ev;
    logic upd_ok;

    rtot_fp_unit u_fp (
        .fp(fp)
    );
    rtot_alarm_cmp u_cmp (
        .total(st_reg.total),
        .thresh(st_reg.alarm_threshold),
        .hit(hit)
    );

    assign fp.mul = st_reg.step == RTOT_MUL;
    assign fp.a = (st_reg.step == RTOT_MUL) ? st_reg.in_value : st_reg.total;
    assign fp.b = (st_reg.step == RTOT_MUL) ? st_reg.scale : st_reg.incr;
    assign wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    assign req = wb_cyc_i && wb_stb_i && !st_reg.ack && !st_reg.err;
    assign wr = req && wb_we_i;
    assign upd_ok = st_reg.run && !st_reg.freeze_control && !st_reg.bad && !st_reg.clear;

    always_comb
    begin
        st_next = st_reg;
        ev = 3'h0;
        st_next.ack = 1'b0;
        st_next.err = 1'b0;
        // update tick
        if (st_reg.tick_cnt >= 32'(TICK_CYCLES - 1))
            st_next.tick_cnt = 32'h0;
        else
            st_next.tick_cnt = st_reg.tick_cnt + 32'h1;
        unique case (st_reg.step)
            RTOT_IDLE:
            begin
                if (st_reg.tick_cnt == 32'h0 && upd_ok)
                    st_next.step = RTOT_MUL;
            end
            RTOT_MUL:
            begin
                st_next.incr = fp.res;
                st_next.step = RTOT_ADD;
                if (!upd_ok)
                    st_next.step = RTOT_IDLE;
            end
            RTOT_ADD:
            begin
                if (upd_ok)
                begin
                    st_next.total = fp.res;
                    if (fp.ovf)
                        ev[`RTOT_INT_SAT] = 1'b1;
                end
                st_next.step = RTOT_DONE;
            end
            RTOT_DONE:
                st_next.step = RTOT_IDLE;
        endcase
        if (st_reg.bad && st_reg.run)
            ev[`RTOT_INT_BAD] = 1'b1;
        // alarm tested while running or frozen
        if (st_reg.run && hit)
            st_next.alarm_flag = 1'b1;
        if (!st_reg.run)
            st_next.alarm_flag = 1'b0;
        if (hit && st_reg.run && !st_reg.alarm_flag)
            ev[`RTOT_INT_ALARM] = 1'b1;
        // register bus
        st_next.rdata = 32'h0;
        if (req)
        begin
            st_next.ack = 1'b1;
            unique case (wb_adr_i)
                `RTOT_OFS_CTRL:
                begin
                    st_next.rdata = {25'h0, st_reg.total_decimal_places, st_reg.bad,
                        st_reg.clear, st_reg.freeze_control, st_reg.run};
                    if (wr && wb_sel_i[0])
                    begin
                        st_next.run = wb_dat_i[`RTOT_CTRL_RUN];
                        st_next.freeze_control = wb_dat_i[`RTOT_CTRL_FREEZE];
                        st_next.clear = wb_dat_i[`RTOT_CTRL_CLEAR];
                        st_next.bad = wb_dat_i[`RTOT_CTRL_BAD];
                        if (wb_dat_i[`RTOT_CTRL_DP_HI:`RTOT_CTRL_DP_LO] <= `RTOT_DP_MAX)
                            st_next.total_decimal_places =
                                wb_dat_i[`RTOT_CTRL_DP_HI:`RTOT_CTRL_DP_LO];
                    end
                end
                `RTOT_OFS_INPUT:
                begin
                    st_next.rdata = st_reg.in_value;
                    if (wr)
                        st_next.in_value = (st_reg.in_value & ~wmask) | (wb_dat_i & wmask);
                end
                `RTOT_OFS_THRESH:
                begin
                    st_next.rdata = st_reg.alarm_threshold;
                    if (wr)
                    begin
                        st_next.alarm_threshold =
                            (st_reg.alarm_threshold & ~wmask) | (wb_dat_i & wmask);
                        st_next.alarm_flag = 1'b0;
                    end
                end
                `RTOT_OFS_TOTAL:
                    st_next.rdata = st_reg.total;
                `RTOT_OFS_STATUS:
                    st_next.rdata = {31'h0, st_reg.alarm_flag};
                `RTOT_OFS_INT_STAT:
                    st_next.rdata = {29'h0, st_reg.int_stat};
                `RTOT_OFS_INT_MASK:
                begin
                    st_next.rdata = {29'h0, st_reg.int_mask};
                    if (wr && wb_sel_i[0])
                        st_next.int_mask = wb_dat_i[2:0];
                end
                `RTOT_OFS_SCALE:
                begin
                    st_next.rdata = st_reg.scale;
                    if (wr)
                        st_next.scale = (st_reg.scale & ~wmask) | (wb_dat_i & wmask);
                end
                default:
                begin
                    st_next.ack = 1'b0;
                    st_next.err = 1'b1;
                end
            endcase
        end
        // write one to clear, new events win
        if (wr && wb_adr_i == `RTOT_OFS_INT_STAT && wb_sel_i[0])
            st_next.int_stat = st_reg.int_stat & ~wb_dat_i[2:0];
        st_next.int_stat = st_next.int_stat | ev;
        if (st_reg.clear)
        begin
            st_next.total = `RTOT_FP_ZERO;
            st_next.alarm_flag = 1'b0;
            st_next.step = RTOT_IDLE;
        end
    end

    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
            st_reg <= ST_RESET;
        else
            st_reg <= st_next;
    end

    assign wb_ack_o = st_reg.ack;
    assign wb_err_o = st_reg.err;
    assign wb_dat_o = st_reg.rdata;
    assign total = st_reg.total;
    assign alarm_flag = st_reg.alarm_flag;
    assign irq = |(st_reg.int_stat & st_reg.int_mask);
endmodule : rtot_totalizer

//--- bench/rtot_props.sv
// port-level checks of the totalizer
`timescale 1ns/10ps
module rtot_chk
#(
    parameter int TICK_CYCLES = 1000
)
(
    // clock and reset
    input wire logic clock,
    input wire logic resetn,
    // wishbone
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic wb_err_o,
    // results
    input wire logic [31:0] total,
    input wire logic alarm_flag,
    input wire logic irq
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!resetn);
    logic wr_done;
    assign wr_done = wb_ack_o && wb_we_i && wb_sel_i[0];
    logic [31:0] lane_mask;
    logic [31:0] thr_seen;
    logic clear_seen;
    assign lane_mask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    // threshold and clear control as last written over the bus
    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            thr_seen <= 32'h0;
            clear_seen <= 1'b0;
        end
        else if (wb_ack_o && wb_we_i)
        begin
            if (wb_adr_i == 8'h08)
                thr_seen <= (thr_seen & ~lane_mask) | (wb_dat_i & lane_mask);
            if (wb_adr_i == 8'h00 && wb_sel_i[0])
                clear_seen <= wb_dat_i[2];
        end
    end
    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held two cycles");
    bus_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o
        |=> wb_ack_o || wb_err_o)
        else $error("request not answered next cycle");
    dat_idle_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
        else $error("read data outside ack");
    no_overflow_a: assert property (total[30:23] != 8'hff)
        else $error("total left float range");
    thr_write_a: assert property (wr_done && wb_adr_i == 8'h08 |-> ##[0:2] !alarm_flag)
        else $error("alarm kept over threshold write");
    clear_total_a: assert property (wr_done && wb_adr_i == 8'h00 && wb_dat_i[2]
        |-> ##[1:3] (total == 32'h0 && !alarm_flag))
        else $error("clear did not zero total");
    reset_state_a: assert property (disable iff (1'b0) !resetn
        |-> total == 32'h0 && !alarm_flag && !irq)
        else $error("outputs set during reset");
    alarm_cause_a: assert property ($rose(alarm_flag) |-> $past(total) != 32'h0)
        else $error("alarm rose at zero total");
    zero_thr_a: assert property (thr_seen[30:0] == 31'h0 |-> !alarm_flag)
        else $error("alarm on with zero threshold");
    clear_hold_a: assert property (clear_seen |=> total == 32'h0 && !alarm_flag)
        else $error("clear held but total or alarm set");
endmodule : rtot_chk

//--- bench/rtot_src.sv
// bus-side source of rate input and run, freeze and clear controls
`timescale 1ns/10ps
module rtot_src
(
    // clock
    input wire logic clock,
    // wishbone master
    output logic wb_cyc_o,
    output logic wb_stb_o,
    output logic wb_we_o,
    output logic [7:0] wb_adr_o,
    output logic [3:0] wb_sel_o,
    output logic [31:0] wb_dat_o,
    input wire logic [31:0] wb_dat_i,
    input wire logic wb_ack_i,
    input wire logic wb_err_i
);
    initial
    begin
        wb_cyc_o = 1'b0;
        wb_stb_o = 1'b0;
        wb_we_o = 1'b0;
        wb_adr_o = 8'h00;
        wb_sel_o = 4'hf;
        wb_dat_o = 32'h0;
    end
    task automatic xfer(input logic we, input logic [7:0] adr, input logic [31:0] wd,
        output logic [31:0] rd, output logic err);
        @(posedge clock);
        wb_cyc_o <= 1'b1;
        wb_stb_o <= 1'b1;
        wb_we_o <= we;
        wb_adr_o <= adr;
        wb_sel_o <= 4'hf;
        wb_dat_o <= wd;
        // answer looked at mid-cycle, where it stands settled until the next edge
        do
            @(negedge clock);
        while (!(wb_ack_i || wb_err_i));
        rd = wb_dat_i;
        err = wb_err_i;
        @(posedge clock);
        wb_cyc_o <= 1'b0;
        wb_stb_o <= 1'b0;
        wb_we_o <= ~we;
        wb_adr_o <= ~adr;
        wb_sel_o <= 4'h0;
        wb_dat_o <= ~wd;
        @(posedge clock);
    endtask : xfer
endmodule : rtot_src

//--- bench/rtot_totalizer_tb.sv
// self-checking bench for the rate totalizer
`timescale 1ns/10ps
module rtot_totalizer_tb;
    logic clock, resetn, cyc, stb, we, ack, err, alarm, irq;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] dat_w, dat_r, total;
    int failures;
    int comparisons;
    rtot_totalizer #(.TICK_CYCLES(4)) u_dut (.clock(clock), .resetn(resetn),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
        .wb_dat_i(dat_w), .wb_dat_o(dat_r), .wb_ack_o(ack), .wb_err_o(err),
        .total(total), .alarm_flag(alarm), .irq(irq));
    rtot_src u_src (.clock(clock), .wb_cyc_o(cyc), .wb_stb_o(stb), .wb_we_o(we),
        .wb_adr_o(adr), .wb_sel_o(sel), .wb_dat_o(dat_w), .wb_dat_i(dat_r),
        .wb_ack_i(ack), .wb_err_i(err));
    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp)
        begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask : check
    task automatic settle(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask : settle
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        u_src.xfer(1'b1, a, d, r, e);
        #1;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string name);
        logic [31:0] r;
        logic e;
        u_src.xfer(1'b0, a, 32'h0, r, e);
        check(name, exp, r);
        check("err", {31'h0, a > 8'h1c}, {31'h0, e});
    endtask : rd
    task automatic next_total(input logic [31:0] exp, input string name);
        logic [31:0] old;
        int n;
        old = total;
        n = 0;
        while (total === old && n < 40)
        begin
            @(posedge clock);
            #1;
            n++;
        end
        #1;
        check(name, exp, total);
    endtask : next_total
    task automatic start(input logic [31:0] thr, input logic [31:0] inp);
        wr(8'h00, 32'h4);
        wr(8'h08, thr);
        wr(8'h04, inp);
        wr(8'h00, 32'h1);
    endtask : start
    task automatic t_still(input logic [31:0] c, input string name);
        logic [31:0] held;
        wr(8'h00, 32'h1);
        settle(8);
        wr(8'h00, c);
        settle(4);
        held = total;
        settle(16);
        check(name, held, total);
    endtask : t_still
    task automatic t_reset;
        check("total", 32'h0, total);
        check("alarm", 32'h0, {31'h0, alarm});
        rd(8'h00, 32'h0, "ctrl");
        rd(8'h1c, 32'h3f80_0000, "scale");
        rd(8'h20, 32'h0, "unmapped");
    endtask : t_reset
    task automatic t_ramp;
        wr(8'h18, 32'h1);
        start(32'h4000_0000, 32'h3f80_0000);
        next_total(32'h3f80_0000, "total 1");
        next_total(32'h4000_0000, "total 2");
        settle(1);
        check("alarm at setpoint", 32'h0, {31'h0, alarm});
        next_total(32'h4040_0000, "total 3");
        settle(1);
        check("alarm above", 32'h1, {31'h0, alarm});
        check("irq", 32'h1, {31'h0, irq});
        t_still(32'h3, "frozen");
        check("frozen alarm", 32'h1, {31'h0, alarm});
        rd(8'h10, 32'h1, "status");
        wr(8'h14, 32'h1);
        check("irq cleared", 32'h0, {31'h0, irq});
        wr(8'h0c, 32'h0);
        rd(8'h0c, total, "total ro");
        wr(8'h08, 32'h42c8_0000);
        check("alarm threshold write", 32'h0, {31'h0, alarm});
        wr(8'h00, 32'h7);
        settle(2);
        check("clear total", 32'h0, total);
    endtask : t_ramp
    task automatic t_neg;
        start(32'hbfc0_0000, 32'hbf80_0000);
        next_total(32'hbf80_0000, "total -1");
        settle(1);
        check("alarm -1", 32'h0, {31'h0, alarm});
        next_total(32'hc000_0000, "total -2");
        settle(1);
        check("alarm -2", 32'h1, {31'h0, alarm});
        wr(8'h00, 32'h0);
        check("alarm run off", 32'h0, {31'h0, alarm});
    endtask : t_neg
    task automatic t_misc;
        wr(8'h1c, 32'h4000_0000);
        start(32'h0, 32'h3f80_0000);
        next_total(32'h4000_0000, "scaled");
        wr(8'h1c, 32'h3f80_0000);
        settle(30);
        check("zero setpoint", 32'h0, {31'h0, alarm});
        t_still(32'h9, "bad input");
        t_still(32'h0, "run off");
        start(32'h0, 32'h4b80_0000);
        next_total(32'h4b80_0000, "big 1");
        next_total(32'h4c00_0000, "big 2");
        wr(8'h04, 32'h3f80_0000);
        t_still(32'h1, "absorbed");
        start(32'h0, 32'h7f7f_ffff);
        settle(20);
        check("sat pos", 32'h7f7f_ffff, total);
        wr(8'h04, 32'hff7f_ffff);
        settle(30);
        check("sat neg", 32'hff7f_ffff, total);
        for (int i = 0; i < 6; i++)
        begin
            wr(8'h00, 32'(i) << 4);
            rd(8'h00, 32'(i > 4 ? 4 : i) << 4, "places");
        end
    endtask : t_misc
    task automatic finish_test;
        $display("failures %0d comparisons %0d", failures, comparisons);
        if (failures == 0 && comparisons > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : finish_test
    initial
    begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end
    initial
    begin
        repeat (20000) @(posedge clock);
        failures++;
        finish_test();
    end
    initial
    begin
        failures = 0;
        comparisons = 0;
        resetn = 1'b0;
        repeat (6) @(posedge clock);
        resetn <= 1'b1;
        settle(1);
        t_reset();
        t_ramp();
        t_neg();
        t_misc();
        finish_test();
    end
endmodule : rtot_totalizer_tb
bind rtot_totalizer rtot_chk #(.TICK_CYCLES(TICK_CYCLES)) u_chk (.clock(clock),
    .resetn(resetn), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o), .total(total), .alarm_flag(alarm_flag),
    .irq(irq));
